// ==== verilog/dgc_top.sv ====
`timescale 1ns/1ps
`include "dgc_cfg.svh"

// Function
// - Group one low forces clear code
// - Clear never alters data registers
// - Release reloads latch from data register
// - Release reload ignores sync load select
// - Clear high allows normal write/load path
// - Group zero input behaves identically, independently
module dgc_top
    import dgc_pkg::*;
#(
    parameter int                       NUM_DAC        = `DGC_NUM_DAC,
    parameter int                       DAC_W          = `DGC_DAC_W,
    parameter logic [`DGC_NUM_DAC-1:0]  GROUP_ONE_MASK = `DGC_GROUP_ONE_MASK,
    parameter logic [`DGC_DAC_W-1:0]    CLEAR_CODE     = `DGC_CLEAR_CODE
) (
    // Clock and reset
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     RESET_I,
    // Clear pins, active low, asynchronous
    input  wire logic                     GROUP_ZERO_CLEAR_N_I,
    input  wire logic                     GROUP_ONE_CLEAR_N_I,
    // Data register write and load path
    input  wire dgc_wr_s                  DATA_WR_I,
    input  wire logic [NUM_DAC-1:0]       SYNC_LOAD_SELECT_I,
    input  wire logic                     LOAD_STROBE_I,
    // Converter side
    output logic [NUM_DAC*DAC_W-1:0]      LATCH_O,
    output logic [NUM_DAC*DAC_W-1:0]      DATA_REG_O,
    output logic [NUM_DAC-1:0]            CLEAR_ACTIVE_O,
    output logic [`DGC_NUM_GRP-1:0]       GROUP_CLEAR_O
);

    // ======================================================
    // Decode helpers
    function automatic logic wr_hit(input dgc_wr_s wr, input int k);
        wr_hit = wr.valid && (int'(wr.idx) == k);
    endfunction

    // ======================================================
    // Clear pin synchronisers
    logic [`DGC_NUM_GRP-1:0] clear_n_sync;
    logic [`DGC_NUM_GRP-1:0] clear_n_pin;

    assign clear_n_pin = {GROUP_ONE_CLEAR_N_I, GROUP_ZERO_CLEAR_N_I};

    genvar g;
    generate
        for (g = 0; g < `DGC_NUM_GRP; g++) begin : g_sync
            // Metastable pin never reaches latch control directly
            dgc_sync #(
                .RESET_VAL (1'b1)
            ) u_dgc_sync (
                .clk_i   (CORE_CLK_I),
                .rst_i   (RESET_I),
                .async_i (clear_n_pin[g]),
                .level_o (clear_n_sync[g])
            );
        end
    endgenerate

    // ======================================================
    // Per-group clear state machines
    dgc_grp_e                grp_state_reg  [`DGC_NUM_GRP];
    dgc_grp_e                grp_state_next [`DGC_NUM_GRP];
    logic [`DGC_NUM_GRP-1:0] grp_in_clear;
    logic [`DGC_NUM_GRP-1:0] grp_restore;

    generate
        for (g = 0; g < `DGC_NUM_GRP; g++) begin : g_grp
            // Each group follows only its own pin
            always_comb begin
                grp_state_next[g] = grp_state_reg[g];
                case (grp_state_reg[g])
                    GRP_NORMAL: begin
                        if (!clear_n_sync[g]) begin
                            grp_state_next[g] = GRP_CLEAR;
                        end
                    end
                    GRP_CLEAR: begin
                        if (clear_n_sync[g]) begin
                            grp_state_next[g] = GRP_NORMAL;
                        end
                    end
                    default: begin
                        grp_state_next[g] = GRP_NORMAL;
                    end
                endcase
            end

            // State register
            always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    grp_state_reg[g] <= GRP_NORMAL;
                end else begin
                    grp_state_reg[g] <= grp_state_next[g];
                end
            end

            // Clear level and one-cycle restore pulse on release
            assign grp_in_clear[g] = (grp_state_reg[g] == GRP_CLEAR);
            assign grp_restore[g]  = grp_in_clear[g] && clear_n_sync[g];
        end
    endgenerate

    // ======================================================
    // Data registers and output latches
    logic [DAC_W-1:0]   data_reg   [NUM_DAC];
    logic [DAC_W-1:0]   data_next  [NUM_DAC];
    logic [DAC_W-1:0]   latch_reg  [NUM_DAC];
    logic [DAC_W-1:0]   latch_next [NUM_DAC];
    logic [NUM_DAC-1:0] dac_clear;
    logic [NUM_DAC-1:0] dac_restore;
    logic [NUM_DAC-1:0] dac_wr;
    logic [NUM_DAC-1:0] dac_load;
    logic [NUM_DAC-1:0] clear_active_reg;

    genvar k;
    generate
        for (k = 0; k < NUM_DAC; k++) begin : g_dac
            // Group selection and request decode
            assign dac_clear[k]   = grp_in_clear[GROUP_ONE_MASK[k]];
            assign dac_restore[k] = grp_restore[GROUP_ONE_MASK[k]];
            assign dac_wr[k]      = wr_hit(DATA_WR_I, k);
            assign dac_load[k]    = LOAD_STROBE_I && SYNC_LOAD_SELECT_I[k];

            // Data register only listens to writes, clear has no say
            assign data_next[k] = dac_wr[k] ? DATA_WR_I.value : data_reg[k];

            // Latch source priority: clear, restore, direct write, strobed load
            assign latch_next[k] =
                (dac_clear[k] && !dac_restore[k])       ? CLEAR_CODE   :
                dac_restore[k]                          ? data_next[k] :
                (dac_wr[k] && !SYNC_LOAD_SELECT_I[k])   ? DATA_WR_I.value :
                dac_load[k]                             ? data_reg[k]  :
                latch_reg[k];

            // Storage
            always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    data_reg[k]         <= `DGC_DATA_RESET;
                    latch_reg[k]        <= `DGC_DATA_RESET;
                    clear_active_reg[k] <= 1'b0;
                end else begin
                    data_reg[k]         <= data_next[k];
                    latch_reg[k]        <= latch_next[k];
                    clear_active_reg[k] <= dac_clear[k] && !dac_restore[k];
                end
            end

            assign LATCH_O[k*DAC_W +: DAC_W]    = latch_reg[k];
            assign DATA_REG_O[k*DAC_W +: DAC_W] = data_reg[k];

            // ==================================================
            // Checks on each converter
            AST_CLEAR_CODE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                (dac_clear[k] && !dac_restore[k]) |=> (latch_reg[k] == CLEAR_CODE))
                else $error("latch did not take clear code");

            AST_DATA_KEPT: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                !dac_wr[k] |=> (data_reg[k] == $past(data_reg[k])))
                else $error("data register changed without write");

            AST_RESTORE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                (dac_restore[k] && !dac_wr[k]) |=> (latch_reg[k] == data_reg[k]))
                else $error("latch not restored from data register");

            AST_RESTORE_BYPASS: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                (dac_restore[k] && SYNC_LOAD_SELECT_I[k] && !LOAD_STROBE_I)
                |=> (latch_reg[k] == data_reg[k]) && !clear_active_reg[k])
                else $error("restore waited for load strobe");

            AST_NORMAL_WRITE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                (!dac_clear[k] && dac_wr[k] && !SYNC_LOAD_SELECT_I[k])
                |=> (latch_reg[k] == data_reg[k]) && (data_reg[k] == $past(DATA_WR_I.value)))
                else $error("normal write did not reach latch");

            AST_HELD_UNTIL_STROBE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                (!dac_clear[k] && !dac_wr[k] && !dac_load[k]) |=> $stable(latch_reg[k]))
                else $error("latch moved without cause");
        end
    endgenerate

    // ======================================================
    // Group sequencing checks
    sequence s_pin_low_held(int gi);
        (!clear_n_pin[gi])[*5];
    endsequence

    sequence s_sync_low_then_clear(int gi);
        !clear_n_sync[gi] ##1 grp_in_clear[gi];
    endsequence

    generate
        for (g = 0; g < `DGC_NUM_GRP; g++) begin : g_chk
            AST_SYNC_DELAY: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                s_pin_low_held(g) |-> !clear_n_sync[g])
                else $error("clear pin not seen after synchroniser delay");

            AST_GROUP_ENTER: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                $fell(clear_n_sync[g]) |-> s_sync_low_then_clear(g))
                else $error("group did not enter clear state");

            AST_GROUP_LEAVE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
                grp_restore[g] |=> !grp_in_clear[g] ##1 !GROUP_CLEAR_O[g])
                else $error("group did not leave clear state");
        end
    endgenerate

    // ======================================================
    // Status outputs
    logic [`DGC_NUM_GRP-1:0] group_clear_reg;

    // Registered copy of group states for observers
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            group_clear_reg <= '0;
        end else begin
            group_clear_reg <= grp_in_clear & ~grp_restore;
        end
    end

    assign GROUP_CLEAR_O  = group_clear_reg;
    assign CLEAR_ACTIVE_O = clear_active_reg;

endmodule // dgc_top

// ==== verilog/dgc_cfg.svh ====
`ifndef DGC_CFG_SVH
`define DGC_CFG_SVH

// ==========================================================
// Converter group sizes
`define DGC_NUM_DAC        12
`define DGC_DAC_W          12
`define DGC_IDX_W          4
`define DGC_NUM_GRP        2

// ==========================================================
// Reset and clear values
`define DGC_CLEAR_CODE     12'h000
`define DGC_DATA_RESET     12'h000
`define DGC_GROUP_ONE_MASK 12'h0FC0

`endif

// ==== verilog/dgc_pkg.sv ====
`include "dgc_cfg.svh"

package dgc_pkg;

    // ======================================================
    // Group clear states
    typedef enum logic {
        GRP_NORMAL,
        GRP_CLEAR
    } dgc_grp_e;

    // ======================================================
    // Data register write request
    typedef struct packed {
        logic                   valid;
        logic [`DGC_IDX_W-1:0]  idx;
        logic [`DGC_DAC_W-1:0]  value;
    } dgc_wr_s;

endpackage

// ==== verilog/dgc_sync.sv ====
`timescale 1ns/1ps

// ==========================================================
// Three-stage pin synchroniser with agreement filter
module dgc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin side
    input  wire logic async_i,
    // Core side
    output logic      level_o
);

    logic [2:0] stage_reg;
    logic       level_reg;
    wire        agree = (stage_reg[1] == stage_reg[2]);

    // First stage feeds only the second; glitches shorter than two edges are dropped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_reg <= {3{RESET_VAL}};
            level_reg <= RESET_VAL;
        end else begin
            stage_reg <= {stage_reg[1:0], async_i};
            if (agree) begin
                level_reg <= stage_reg[2];
            end
        end
    end

    assign level_o = level_reg;

endmodule // dgc_sync

// ==== verif/dgc_host_model.sv ====
`timescale 1ns/1ps

// ==========================================================
// Board logic driving the two clear pins
module dgc_host_model (
    // Clock
    input  wire logic       clk_i,
    // Requested levels, bit g is group g
    input  wire logic [1:0] level_req_i,
    // Clear pins, active low
    output logic            zero_clear_n_o,
    output logic            one_clear_n_o
);
    // Registered like real board logic, changing just after the edge;
    // the first edge lands well inside reset, so the unknown start is harmless
    always @(posedge clk_i) begin
        zero_clear_n_o <= level_req_i[0];
        one_clear_n_o  <= level_req_i[1];
    end
endmodule // dgc_host_model

// ==== verif/dac_group_clear_control_test.sv ====
`timescale 1ns/1ps
`include "dgc_cfg.svh"

// ==========================================================
// Testbench for the group clear control
module dac_group_clear_control_test import dgc_pkg::*;;
    logic                      core_clk;
    logic                      reset;
    logic [1:0]                level_req;
    logic                      zero_n;
    logic                      one_n;
    dgc_wr_s                   wr;
    logic [`DGC_NUM_DAC-1:0]   sel;
    logic                      strobe;
    logic [143:0]              latch;
    logic [143:0]              data;
    logic [`DGC_NUM_DAC-1:0]   clr_act;
    logic [1:0]                grp_clr;
    int                        err_total;
    int                        tests_run;

    dgc_host_model u_dgc_host_model (.clk_i(core_clk), .level_req_i(level_req),
        .zero_clear_n_o(zero_n), .one_clear_n_o(one_n));

    dgc_top u_dgc_top (.CORE_CLK_I(core_clk), .RESET_I(reset),
        .GROUP_ZERO_CLEAR_N_I(zero_n), .GROUP_ONE_CLEAR_N_I(one_n),
        .DATA_WR_I(wr), .SYNC_LOAD_SELECT_I(sel), .LOAD_STROBE_I(strobe),
        .LATCH_O(latch), .DATA_REG_O(data), .CLEAR_ACTIVE_O(clr_act),
        .GROUP_CLEAR_O(grp_clr));

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ======================================================
    // Helpers
    function automatic logic [11:0] lat(input int k);
        return latch[k*12 +: 12];
    endfunction
    function automatic logic [11:0] dreg(input int k);
        return data[k*12 +: 12];
    endfunction
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Sample 1 ns after the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr_one(input logic [3:0] idx, input logic [11:0] v);
        @(posedge core_clk) wr <= {1'b1, idx, v};
        @(posedge core_clk) wr <= '0;
        #1;
    endtask
    task automatic pulse;
        @(posedge core_clk) strobe <= 1'b1;
        @(posedge core_clk) strobe <= 1'b0;
        #1;
    endtask

    // ======================================================
    // Scenarios
    task automatic t_normal;
        wr_one(4'h3, 12'h0a5a);
        chk(dreg(3), 12'h0a5a);
        chk(lat(3), 12'h0a5a);
        wr_one(4'h8, 12'h0123);
        chk(lat(8), 12'h0000);
        pulse();
        chk(lat(8), 12'h0123);
        $display("test normal done");
    endtask

    task automatic t_group_one;
        wr_one(4'h6, 12'h0777);
        pulse();
        wr_one(4'h0, 12'h0111);
        @(posedge core_clk) level_req[1] <= 1'b0;
        cyc(2);
        chk(lat(6), 12'h0777);
        cyc(8);
        chk(lat(6), `DGC_CLEAR_CODE);
        chk(dreg(6), 12'h0777);
        chk({11'h0, clr_act[6]}, 12'h0001);
        chk({10'h0, grp_clr}, 12'h0002);
        chk(lat(0), 12'h0111);
        wr_one(4'h6, 12'h0999);
        pulse();
        chk(dreg(6), 12'h0999);
        chk(lat(6), `DGC_CLEAR_CODE);
        wr_one(4'h0, 12'h0222);
        chk(lat(0), 12'h0222);
        @(posedge core_clk) level_req[1] <= 1'b1;
        cyc(9);
        chk(lat(6), 12'h0999);
        chk({11'h0, clr_act[6]}, 12'h0000);
        $display("test group one done");
    endtask

    task automatic t_group_zero;
        @(posedge core_clk) level_req[0] <= 1'b0;
        cyc(10);
        chk(lat(0), `DGC_CLEAR_CODE);
        chk(lat(6), 12'h0999);
        chk({10'h0, grp_clr}, 12'h0001);
        wr_one(4'h0, 12'h0333);
        chk(dreg(0), 12'h0333);
        chk(lat(0), `DGC_CLEAR_CODE);
        @(posedge core_clk) level_req[0] <= 1'b1;
        cyc(9);
        chk(lat(0), 12'h0333);
        $display("test group zero done");
    endtask

    // ======================================================
    // Verdict
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Converters 6 and 8 wait for the strobe, the rest load directly
    initial begin
        err_total = 0;
        tests_run = 0;
        reset     = 1'b1;
        level_req = 2'b11;
        wr        = '0;
        sel       = 12'h0140;
        strobe    = 1'b0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        cyc(2);
        t_normal();
        t_group_one();
        t_group_zero();
        end_sim();
    end

    // Whole run is about 70 cycles, so this is a wide margin
    initial begin
        #20000;
        err_total++;
        end_sim();
    end
endmodule // dac_group_clear_control_test
